// ### logic/sfb_defs.svh
// Constants for the bank-3 special function register block.
// Assumes 9-bit data addresses and 8-bit registers.
`ifndef SFB_DEFS_SVH
`define SFB_DEFS_SVH
`define SFB_ADR_INDIRECT 9'h180
`define SFB_ADR_OPTION 9'h181
`define SFB_ADR_PCL 9'h182
`define SFB_ADR_STATUS 9'h183
`define SFB_ADR_POINTER 9'h184
`define SFB_ADR_PORT_B_DIRECTION 9'h186
`define SFB_ADR_PROGRAM_COUNTER_HIGH_LATCH 9'h18A
`define SFB_ADR_INTERRUPT_CONTROL 9'h18B
`define SFB_LOW_MASK 7'h7F
`define SFB_RST_OPTION 8'hFF
`define SFB_RST_PCL 8'h00
`define SFB_RST_STATUS 8'h18
`define SFB_RST_PORT_B_DIRECTION 8'hFF
`define SFB_RST_PROGRAM_COUNTER_HIGH_LATCH 8'h00
`define SFB_RST_INTERRUPT_CONTROL 8'h00
`define SFB_RST_POINTER 8'h00
`define SFB_PROGRAM_COUNTER_HIGH_LATCH_MASK 8'h1F
`define SFB_BIT_C 0
`define SFB_BIT_DC 1
`define SFB_BIT_Z 2
`define SFB_BIT_PD 3
`define SFB_BIT_TO 4
`define SFB_BIT_RP0 5
`define SFB_BIT_RP1 6
`define SFB_BIT_IRP 7
`define SFB_BANK3 2'h3
`endif

// ### logic/sfb_pkg.sv
// Types shared by the bank-3 register block.
// Assumes the defs header is compiled alongside.
package sfb_pkg;
   typedef enum logic [3:0] {
      SFB_BANK_0 = 4'h1,
      SFB_BANK_1 = 4'h2,
      SFB_BANK_2 = 4'h4,
      SFB_BANK_3 = 4'h8
   } sfb_bank_t;
endpackage

// ### logic/sfb_bank_decode.sv
// Direct address bank decoder.
// Assumes a 7-bit in-bank offset from the instruction.
`timescale 1ns/100ps
`include "sfb_defs.svh"
module sfb_bank_decode
   import sfb_pkg::*;
(
   // Select and offset
   input wire logic [1:0] bank_sel,
   input wire logic [6:0] offset,
   // Result
   output sfb_bank_t bank,
   output logic [8:0] full_addr
);
   always_comb begin
      case (bank_sel)
         2'h0: bank = SFB_BANK_0;
         2'h1: bank = SFB_BANK_1;
         2'h2: bank = SFB_BANK_2;
         default: bank = SFB_BANK_3;
      endcase
   end
   assign full_addr = {bank_sel, offset};
endmodule

// ### logic/sfb_flag_calc.sv
// Flag computation for add and subtract results.
// Assumes the core applies carry flags only for arithmetic operations.
`timescale 1ns/100ps
module sfb_flag_calc (
   // Operands
   input wire logic [7:0] op_a,
   input wire logic [7:0] op_b,
   input wire logic is_sub,
   // Result and flags
   output logic [7:0] result,
   output logic carry,
   output logic nibble_carry,
   output logic zero
);
   logic [8:0] full;
   logic [4:0] low;
   always_comb begin
      // Subtraction as a + ~b + 1 gives inverted borrow directly
      if (is_sub) begin
         full = {1'b0, op_a} + {1'b0, ~op_b} + 9'h001;
         low = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]} + 5'h01;
      end else begin
         full = {1'b0, op_a} + {1'b0, op_b};
         low = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
      end
   end
   assign result = full[7:0];
   assign carry = full[8];
   assign nibble_carry = low[4];
   assign zero = (full[7:0] == 8'h00);
endmodule

// ### logic/sfb_bank3_regs.sv
// Bank-3 special function registers and the status register write path.
// Assumes the core presents one access per cycle, reads are combinational
// in the address and returned registered one cycle later.
`timescale 1ns/100ps
`include "sfb_defs.svh"
module sfb_bank3_regs
   import sfb_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Core access
   input wire logic [6:0] acc_offset,
   input wire logic acc_wr,
   input wire logic [7:0] acc_wdata,
   input wire logic acc_clear,
   input wire logic acc_flags_upd,
   input wire logic acc_carry_upd,
   input wire logic [7:0] alu_a,
   input wire logic [7:0] alu_b,
   input wire logic alu_sub,
   // Core events
   input wire logic watchdog_clear_instr,
   input wire logic sleep_instr,
   input wire logic watchdog_timeout,
   // Read data
   output logic [7:0] rd_data_q,
   output logic rd_hit_q,
   // Register outputs
   output logic [7:0] status_q,
   output logic [7:0] option_q,
   output logic [7:0] pcl_q,
   output logic [7:0] pointer_q,
   output logic [7:0] port_b_direction_q,
   output logic [7:0] program_counter_high_latch_q,
   output logic [7:0] interrupt_control_q,
   output logic [8:0] indirect_addr_q
);
   ////////////////////////////////////////////////////////////////////////
   sfb_bank_t bank;
   logic [8:0] addr;
   logic [7:0] alu_res;
   logic alu_c, alu_dc, alu_z;
   logic is_bank3, sel_status, sel_option, sel_pcl, sel_pointer;
   logic sel_port_b_direction, sel_program_counter_high_latch, sel_interrupt_control, sel_indirect, sel_any;
   logic wr_en;
   logic [7:0] wr_val;
   logic [7:0] status_d;
   logic [7:0] rd_d;

   sfb_bank_decode u_dec (
      .bank_sel(status_q[`SFB_BIT_RP1:`SFB_BIT_RP0]),
      .offset(acc_offset),
      .bank(bank),
      .full_addr(addr)
   );

   sfb_flag_calc u_alu (
      .op_a(alu_a),
      .op_b(alu_b),
      .is_sub(alu_sub),
      .result(alu_res),
      .carry(alu_c),
      .nibble_carry(alu_dc),
      .zero(alu_z)
   );

   ////////////////////////////////////////////////////////////////////////
   // Shared entries match on the in-bank offset alone, so every bank writes and
   // reads the same physical register; rd_hit_q flags the read only in bank 3.
   always_comb begin
      is_bank3 = (bank == SFB_BANK_3);
      sel_indirect = (acc_offset ==
         (`SFB_ADR_INDIRECT & {2'h0, `SFB_LOW_MASK}));
      sel_pcl = (acc_offset ==
         (`SFB_ADR_PCL & {2'h0, `SFB_LOW_MASK}));
      sel_status = (acc_offset ==
         (`SFB_ADR_STATUS & {2'h0, `SFB_LOW_MASK}));
      sel_pointer = (acc_offset ==
         (`SFB_ADR_POINTER & {2'h0, `SFB_LOW_MASK}));
      sel_program_counter_high_latch = (acc_offset ==
         (`SFB_ADR_PROGRAM_COUNTER_HIGH_LATCH & {2'h0, `SFB_LOW_MASK}));
      sel_interrupt_control = (acc_offset ==
         (`SFB_ADR_INTERRUPT_CONTROL & {2'h0, `SFB_LOW_MASK}));
      // Option and direction are local to banks 1 and 3
      sel_option = (acc_offset ==
         (`SFB_ADR_OPTION & {2'h0, `SFB_LOW_MASK})) &&
         (bank == SFB_BANK_3 || bank == SFB_BANK_1);
      sel_port_b_direction = (acc_offset ==
         (`SFB_ADR_PORT_B_DIRECTION & {2'h0, `SFB_LOW_MASK})) &&
         (bank == SFB_BANK_3 || bank == SFB_BANK_1);
      sel_any = sel_indirect | sel_pcl | sel_status | sel_pointer |
         sel_program_counter_high_latch | sel_interrupt_control | sel_option | sel_port_b_direction;
   end

   assign wr_en = acc_wr | acc_clear;
   assign wr_val = acc_clear ? 8'h00 : acc_wdata;

   ////////////////////////////////////////////////////////////////////////
   // Status register next value
   always_comb begin
      status_d = status_q;
      if (wr_en && sel_status) begin
         status_d[`SFB_BIT_IRP] = wr_val[`SFB_BIT_IRP];
         status_d[`SFB_BIT_RP1] = wr_val[`SFB_BIT_RP1];
         status_d[`SFB_BIT_RP0] = wr_val[`SFB_BIT_RP0];
         if (!acc_flags_upd && !acc_clear) begin
            status_d[`SFB_BIT_Z] = wr_val[`SFB_BIT_Z];
            status_d[`SFB_BIT_DC] = wr_val[`SFB_BIT_DC];
            status_d[`SFB_BIT_C] = wr_val[`SFB_BIT_C];
         end
      end
      // Flag update from the operation beats the written value
      if (acc_clear) begin
         status_d[`SFB_BIT_Z] = 1'b1;
      end else if (acc_flags_upd) begin
         status_d[`SFB_BIT_Z] = alu_z;
         if (acc_carry_upd) begin
            status_d[`SFB_BIT_DC] = alu_dc;
            status_d[`SFB_BIT_C] = alu_c;
         end
      end
      // Reset-cause flags change only on core events
      if (watchdog_timeout) begin
         status_d[`SFB_BIT_TO] = 1'b0;
      end else if (watchdog_clear_instr || sleep_instr) begin
         status_d[`SFB_BIT_TO] = 1'b1;
      end
      if (sleep_instr) begin
         status_d[`SFB_BIT_PD] = 1'b0;
      end else if (watchdog_clear_instr) begin
         status_d[`SFB_BIT_PD] = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_q <= `SFB_RST_STATUS;
      end else begin
         status_q <= status_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Plain registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         option_q <= `SFB_RST_OPTION;
         port_b_direction_q <= `SFB_RST_PORT_B_DIRECTION;
         pointer_q <= `SFB_RST_POINTER;
         program_counter_high_latch_q <= `SFB_RST_PROGRAM_COUNTER_HIGH_LATCH;
         interrupt_control_q <= `SFB_RST_INTERRUPT_CONTROL;
         pcl_q <= `SFB_RST_PCL;
      end else if (wr_en) begin
         if (sel_option) begin
            option_q <= wr_val;
         end
         if (sel_port_b_direction) begin
            port_b_direction_q <= wr_val;
         end
         if (sel_pointer) begin
            pointer_q <= wr_val;
         end
         if (sel_program_counter_high_latch) begin
            program_counter_high_latch_q <= wr_val & `SFB_PROGRAM_COUNTER_HIGH_LATCH_MASK;
         end
         if (sel_interrupt_control) begin
            interrupt_control_q <= wr_val;
         end
         if (sel_pcl) begin
            pcl_q <= wr_val;
         end
      end
   end

   // Indirect target: bank bit joins the pointer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         indirect_addr_q <= 9'h000;
      end else begin
         indirect_addr_q <= {status_d[`SFB_BIT_IRP], (wr_en && sel_pointer)
            ? wr_val : pointer_q};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; the indirect entry is not a register and reads zero here,
   // the core redirects that access through the pointer.
   always_comb begin
      rd_d = 8'h00;
      if (sel_status) begin
         rd_d = status_q;
      end else if (sel_option) begin
         rd_d = option_q;
      end else if (sel_pcl) begin
         rd_d = pcl_q;
      end else if (sel_pointer) begin
         rd_d = pointer_q;
      end else if (sel_port_b_direction) begin
         rd_d = port_b_direction_q;
      end else if (sel_program_counter_high_latch) begin
         rd_d = program_counter_high_latch_q;
      end else if (sel_interrupt_control) begin
         rd_d = interrupt_control_q;
      end else begin
         rd_d = 8'h00;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data_q <= 8'h00;
         rd_hit_q <= 1'b0;
      end else begin
         rd_data_q <= rd_d;
         rd_hit_q <= sel_any & is_bank3;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   AST_STATUS_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
      (acc_clear && sel_status && !watchdog_timeout && !sleep_instr &&
      !watchdog_clear_instr) |=> (status_q[7:5] == 3'h0 &&
      status_q[`SFB_BIT_Z] && status_q[4:3] == $past(status_q[4:3]) &&
      status_q[1:0] == $past(status_q[1:0])))
      else $error("register clear of status wrong");
   AST_FLAGS_FROM_ALU: assert property (@(posedge clk) disable iff (sys_rst)
      (acc_flags_upd && acc_carry_upd && !acc_clear) |=>
      (status_q[`SFB_BIT_C] == $past(alu_c) &&
      status_q[`SFB_BIT_Z] == $past(alu_z)))
      else $error("status flags not from operation");
   AST_RESET_FLAGS_RO: assert property (@(posedge clk) disable iff (sys_rst)
      (!watchdog_timeout && !sleep_instr && !watchdog_clear_instr) |=>
      $stable(status_q[4:3]))
      else $error("reset-cause flags changed by write");
   AST_TIMEOUT: assert property (@(posedge clk) disable iff (sys_rst)
      watchdog_timeout |=> !status_q[`SFB_BIT_TO])
      else $error("expiry flag not cleared");
   AST_SLEEP: assert property (@(posedge clk) disable iff (sys_rst)
      (sleep_instr && !watchdog_timeout) |=>
      (status_q[`SFB_BIT_TO] && !status_q[`SFB_BIT_PD]))
      else $error("sleep flags wrong");
   AST_WDT_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
      (watchdog_clear_instr && !sleep_instr && !watchdog_timeout) |=>
      status_q[4:3] == 2'h3)
      else $error("clear watchdog flags wrong");
   AST_UNMAPPED: assert property (@(posedge clk) disable iff (sys_rst)
      !sel_any |=> (rd_data_q == 8'h00 && !rd_hit_q))
      else $error("unmapped read not zero");
   AST_STATUS_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      (acc_wr && !acc_clear && sel_status && !acc_flags_upd) |=>
      status_q[7:5] == $past(acc_wdata[7:5]))
      else $error("status write lost");
   AST_BANK3_HIT: assert property (@(posedge clk) disable iff (sys_rst)
      (sel_status && status_q[6:5] == `SFB_BANK3) |=> rd_hit_q)
      else $error("bank 3 decode wrong");
   AST_SUB_BORROW: assert property (@(posedge clk) disable iff (sys_rst)
      (acc_flags_upd && acc_carry_upd && !acc_clear && alu_sub &&
      alu_a < alu_b) |=> !status_q[`SFB_BIT_C])
      else $error("borrow not inverted");
   COV_CLEAR: cover property (@(posedge clk) acc_clear && sel_status);
   COV_SLEEP: cover property (@(posedge clk) sleep_instr);
   COV_TIMEOUT: cover property (@(posedge clk) watchdog_timeout);
   COV_SUB: cover property (@(posedge clk) acc_flags_upd && alu_sub);
endmodule

// ### test/sfb_core_model.sv
// Behavioural core model: one register access or event per call.
// Assumes the bench calls its tasks in turn; pins change on falling edges.
`timescale 1ns/100ps
module sfb_core_model (
   // Clock
   input wire logic clk,
   // Access
   output logic [6:0] acc_offset,
   output logic acc_wr,
   output logic [7:0] acc_wdata,
   output logic acc_clear,
   output logic acc_flags_upd,
   output logic acc_carry_upd,
   output logic [7:0] alu_a,
   output logic [7:0] alu_b,
   output logic alu_sub,
   // Events
   output logic watchdog_clear_instr,
   output logic sleep_instr,
   output logic watchdog_timeout
);
   initial begin
      {acc_offset, acc_wr, acc_wdata, acc_clear} = 17'h00000;
      {acc_flags_upd, acc_carry_upd, alu_a, alu_b, alu_sub} = 19'h00000;
      {watchdog_clear_instr, sleep_instr, watchdog_timeout} = 3'h0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Strobes last one cycle; data is scrambled after so stale values show
   task automatic idle();
      @(negedge clk);
      {acc_wr, acc_clear, acc_flags_upd, acc_carry_upd} <= 4'h0;
      {watchdog_clear_instr, sleep_instr, watchdog_timeout} <= 3'h0;
      acc_wdata <= ~acc_wdata;
      alu_a <= ~alu_a;
   endtask
   // Plain move: sets no flag from an operation; a write to status loads Z, DC and C from the data
   task automatic wr(input logic [6:0] off, input logic [7:0] d);
      @(negedge clk);
      acc_offset <= off;
      acc_wdata <= d;
      acc_wr <= 1'b1;
      idle();
   endtask
   task automatic clr(input logic [6:0] off);
      @(negedge clk);
      acc_offset <= off;
      acc_clear <= 1'b1;
      idle();
   endtask
   task automatic alu(input logic [6:0] off, input logic [7:0] d,
                      input logic cu, input logic [7:0] a, input logic [7:0] b,
                      input logic sub);
      @(negedge clk);
      acc_offset <= off;
      acc_wdata <= d;
      {acc_wr, acc_flags_upd, acc_carry_upd} <= {2'b11, cu};
      {alu_a, alu_b, alu_sub} <= {a, b, sub};
      idle();
   endtask
   // Event order: clear-watchdog, sleep, timeout
   task automatic evt(input logic [2:0] e);
      @(negedge clk);
      {watchdog_clear_instr, sleep_instr, watchdog_timeout} <= e;
      idle();
   endtask
   task automatic rd(input logic [6:0] off);
      @(negedge clk);
      acc_offset <= off;
      idle();
   endtask
endmodule

// ### test/test_sfb_bank3_regs.sv
// Self-checking bench for the bank-3 register block.
// Assumes the core model drives all access and event inputs.
`timescale 1ns/100ps
module test_sfb_bank3_regs;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [6:0] acc_offset;
   logic acc_wr, acc_clear, acc_flags_upd, acc_carry_upd, alu_sub;
   logic [7:0] acc_wdata, alu_a, alu_b, rd_data_q, status_q, option_q;
   logic [7:0] pcl_q, pointer_q, port_b_direction_q, program_counter_high_latch_q, interrupt_control_q;
   logic watchdog_clear_instr, sleep_instr, watchdog_timeout, rd_hit_q;
   logic [8:0] indirect_addr_q;
   int err_total = 0;
   int num_checks = 0;
   int cycles = 0;
   always #50 clk = ~clk;
   sfb_core_model core (.clk(clk), .acc_offset(acc_offset), .acc_wr(acc_wr),
      .acc_wdata(acc_wdata), .acc_clear(acc_clear),
      .acc_flags_upd(acc_flags_upd), .acc_carry_upd(acc_carry_upd),
      .alu_a(alu_a), .alu_b(alu_b), .alu_sub(alu_sub),
      .watchdog_clear_instr(watchdog_clear_instr), .sleep_instr(sleep_instr),
      .watchdog_timeout(watchdog_timeout));
   sfb_bank3_regs uut (.clk(clk), .sys_rst(sys_rst), .acc_offset(acc_offset),
      .acc_wr(acc_wr), .acc_wdata(acc_wdata), .acc_clear(acc_clear),
      .acc_flags_upd(acc_flags_upd), .acc_carry_upd(acc_carry_upd),
      .alu_a(alu_a), .alu_b(alu_b), .alu_sub(alu_sub),
      .watchdog_clear_instr(watchdog_clear_instr), .sleep_instr(sleep_instr),
      .watchdog_timeout(watchdog_timeout), .rd_data_q(rd_data_q),
      .rd_hit_q(rd_hit_q), .status_q(status_q), .option_q(option_q),
      .pcl_q(pcl_q), .pointer_q(pointer_q), .port_b_direction_q(port_b_direction_q),
      .program_counter_high_latch_q(program_counter_high_latch_q), .interrupt_control_q(interrupt_control_q),
      .indirect_addr_q(indirect_addr_q));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [8:0] seen,
                      input logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      if (err_total == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Run is about 120 cycles; the ceiling leaves wide margin
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("status", status_q, 8'h18);
      chk("option", option_q, 8'hFF);
      chk("pcl", pcl_q, 8'h00);
      chk("port_b_direction", port_b_direction_q, 8'hFF);
      chk("program_counter_high_latch", program_counter_high_latch_q, 8'h00);
      chk("rd_hit", rd_hit_q, 1'b0);
   endtask
   task automatic t_map();
      logic [6:0] offs[6] = '{7'h01, 7'h02, 7'h04, 7'h06, 7'h0A, 7'h0B};
      logic [7:0] dat[6] = '{8'hA5, 8'h3C, 8'hC3, 8'h5A, 8'hFF, 8'h96};
      logic [6:0] bad[7] = '{7'h05, 7'h07, 7'h08, 7'h09, 7'h0C, 7'h1F, 7'h7F};
      core.wr(7'h03, 8'h60);
      chk("status", status_q, 8'h78);
      for (int i = 0; i < 6; i++) begin
         core.wr(offs[i], dat[i]);
         core.rd(offs[i]);
         chk("rd_data", rd_data_q, offs[i] == 7'h0A ? 8'h1F : dat[i]);
         chk("rd_hit", rd_hit_q, 1'b1);
      end
      for (int i = 0; i < 7; i++) begin
         core.wr(bad[i], 8'h55);
         core.rd(bad[i]);
         chk("rd_unmapped", rd_data_q, 8'h00);
         chk("hit_unmapped", rd_hit_q, 1'b0);
      end
      chk("option", option_q, 8'hA5);
      chk("pcl", pcl_q, 8'h3C);
      chk("interrupt_control", interrupt_control_q, 8'h96);
      chk("ind_addr", indirect_addr_q, 9'h0C3);
   endtask
   task automatic t_banks();
      core.wr(7'h03, 8'h18);
      core.wr(7'h01, 8'h00);
      chk("option_b0", option_q, 8'hA5);
      core.wr(7'h04, 8'h11);
      chk("pointer_b0", pointer_q, 8'h11);
      core.rd(7'h04);
      chk("hit_b0", rd_hit_q, 1'b0);
      core.wr(7'h03, 8'h20);
      core.wr(7'h01, 8'h00);
      chk("option_b1", option_q, 8'h00);
      core.wr(7'h03, 8'h40);
      core.wr(7'h06, 8'h0F);
      chk("port_b_direction_b2", port_b_direction_q, 8'h5A);
      core.wr(7'h03, 8'hE0);
      chk("ind_addr", indirect_addr_q, 9'h111);
   endtask
   task automatic t_events();
      logic [2:0] ev[6] = '{3'b010, 3'b001, 3'b100, 3'b101, 3'b110, 3'b001};
      logic [7:0] exp[6] = '{8'hF0, 8'hE0, 8'hF8, 8'hE8, 8'hF0, 8'hE0};
      for (int i = 0; i < 6; i++) begin
         core.evt(ev[i]);
         chk("status_ev", status_q, exp[i]);
      end
      core.wr(7'h03, 8'hFA);
      chk("status_ro", status_q, 8'hE2);
      core.clr(7'h03);
      chk("status_clr", status_q, 8'h06);
      core.clr(7'h04);
      chk("pointer_clr", pointer_q, 8'h00);
   endtask
   task automatic t_alu();
      logic [7:0] at[6] = '{8'h0F, 8'hFF, 8'h10, 8'h01, 8'h05, 8'h80};
      logic [7:0] bt[6] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h05, 8'h80};
      logic [5:0] sub_m = 6'b011100;
      logic [5:0] cu_m = 6'b111110;
      logic [7:0] a, b, r, wd;
      logic c, dc, z;
      logic [1:0] keep;
      core.wr(7'h03, 8'h60);
      for (int i = 0; i < 6; i++) begin
         a = at[i];
         b = bt[i];
         r = sub_m[i] ? a - b : a + b;
         c = sub_m[i] ? (a >= b) : ({1'b0, a} + b > 9'h0FF);
         dc = sub_m[i] ? (a[3:0] >= b[3:0]) :
                         ({1'b0, a[3:0]} + b[3:0] > 5'h0F);
         z = (r == 8'h00);
         wd = {5'b01111, ~z, ~dc, ~c};
         // Without a carry update the written carry bits are still ignored
         keep = status_q[1:0];
         core.alu(7'h03, wd, cu_m[i], a, b, sub_m[i]);
         chk("alu_flags", status_q,
             {5'b01100, z, cu_m[i] ? {dc, c} : keep});
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
      t_reset();
      t_map();
      t_banks();
      t_events();
      t_alu();
      close_out();
   end
endmodule
